// *** common/acl_match_consts.svh ***
// Functional notes
// R1 - VLAN ID any: frame VLAN ID ignored
// R2 - Specific VLAN ID 1..4095 must equal frame's
// R3 - Tag priority any, or 0..7 must equal
// R4 - ARP checks apply only for ARP frame type
// R5 - Opcode class: any, ARP, RARP, other
// R6 - Request/reply: requests, replies, or any
// R7 - Sender IP host mode: exact equality
// R8 - Sender IP network mode: masked equality
// R9 - Target IP host mode: exact equality
// R10 - Target IP network mode: masked equality
// R11 - Sender hardware vs source MAC: eq/ne/any
// R12 - RARP target hardware vs source MAC: eq/ne/any
// R13 - Length check 1: HLN 6 and PLN 4
// R14 - Hardware space check 1: HRD equals 1
// R15 - Protocol space check 1: PRO equals 0x800
// R16 - Each three-way check has don't-care
// R17 - Setting 0 matches when field differs
// R18 - Hit needs all active criteria (AND)
// R19 - Each hit increments the hit counter
`ifndef ACL_MATCH_CONSTS_SVH
`define ACL_MATCH_CONSTS_SVH

// Register byte offsets
`define REG_CFG0 8'h00
`define REG_CFG1 8'h04
`define REG_SIP_ADDR 8'h08
`define REG_SIP_MASK 8'h0c
`define REG_TIP_ADDR 8'h10
`define REG_TIP_MASK 8'h14
`define REG_HIT_CNT 8'h18
`define REG_STATUS 8'h1c

// Field positions in the first configuration word
`define VID_LSB 0
`define VID_MSB 11
`define VID_SPEC_BIT 12
`define PRIO_LSB 13
`define PRIO_MSB 15
`define PRIO_SPEC_BIT 16
`define OPCLS_LSB 17
`define REQREP_LSB 19
`define SIPMODE_LSB 21
`define TIPMODE_LSB 23
`define SHACHK_LSB 25
`define THACHK_LSB 27
`define CFG0_USED_MSB 28

// Field positions in the second configuration word
`define LENCHK_LSB 0
`define HRDCHK_LSB 2
`define PROCHK_LSB 4
`define FTYPE_LSB 6
`define CFG1_USED_MSB 8

// Status bits
`define STAT_HIT_BIT 0
`define STAT_SEEN_BIT 1

// Reset values
`define CFG0_RST 32'h0000_0000
`define CFG1_RST 32'h0000_0000
`define ADDR_RST 32'h0000_0000

// Protocol constants
`define VID_NONE 12'h000
`define OP_ARP_REQ 16'h0001
`define OP_ARP_REP 16'h0002
`define OP_RARP_REQ 16'h0003
`define OP_RARP_REP 16'h0004
`define HLN_ETH 8'h06
`define PLN_IPV4 8'h04
`define HRD_ETH 16'h0001
`define PRO_IPV4 16'h0800

`endif

// *** common/acl_match_pkg.sv ***
package acl_match_pkg;
    // Frame type selection of the filter entry
    typedef enum logic [2:0] {
        FT_ANY = 3'h0,
        FT_ETYPE = 3'h1,
        FT_ARP = 3'h2,
        FT_IPV4 = 3'h3,
        FT_IPV6 = 3'h4
    } ftype_sel_t;
    // Frame class reported by the ingress parser
    typedef enum logic [1:0] {
        FK_ETYPE = 2'h0,
        FK_ARP = 2'h1,
        FK_IPV4 = 2'h2,
        FK_IPV6 = 2'h3
    } frame_kind_t;
    // Opcode class selection
    typedef enum logic [1:0] {
        OC_ANY = 2'h0,
        OC_ARP = 2'h1,
        OC_RARP = 2'h2,
        OC_OTHER = 2'h3
    } opcls_t;
    // Request or reply selection
    typedef enum logic [1:0] {
        RR_ANY = 2'h0,
        RR_REQ = 2'h1,
        RR_REP = 2'h2,
        RR_ANY_ALT = 2'h3
    } reqrep_t;
    // Protocol address filter mode
    typedef enum logic [1:0] {
        IP_ANY = 2'h0,
        IP_HOST = 2'h1,
        IP_NET = 2'h2,
        IP_RSVD = 2'h3
    } ipmode_t;
    // Three-way check: high bit active, low bit wanted equality
    typedef enum logic [1:0] {
        TW_ANY = 2'h0,
        TW_ANY_ALT = 2'h1,
        TW_NE = 2'h2,
        TW_EQ = 2'h3
    } tri_t;
endpackage

// *** rtl/acl_vlan_arp_matcher.sv ***
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "acl_match_consts.svh"

module acl_vlan_arp_matcher
#(
    parameter int CNT_W = 32 // Hit counter width
)
(
    input wire logic clk_i, // 200 MHz clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte enables
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic frm_valid_i, // Frame header fields valid
    input wire acl_match_pkg::frame_kind_t frm_kind_i, // Frame class
    input wire logic [11:0] frm_vid_i, // VLAN identifier
    input wire logic [2:0] frm_prio_i, // Tag priority
    input wire logic [47:0] frame_source_mac_i, // Source MAC
    input wire logic [15:0] arp_op_i, // ARP opcode
    input wire logic [15:0] arp_hrd_i, // Hardware space
    input wire logic [15:0] arp_pro_i, // Protocol space
    input wire logic [7:0] arp_hln_i, // Hardware address length
    input wire logic [7:0] arp_pln_i, // Protocol address length
    input wire logic [47:0] arp_sender_hw_i, // Sender hardware addr
    input wire logic [31:0] arp_sender_ip_i, // Sender IP
    input wire logic [47:0] arp_target_hw_i, // Target hardware addr
    input wire logic [31:0] arp_target_ip_i, // Target IP
    output logic decided_o, // One-cycle pulse per decision
    output logic hit_o // Frame hit the filter entry
);
    import acl_match_pkg::*;

    // Counter must fit the 32-bit read word; refused at elaboration
    if (CNT_W < 1 || CNT_W > 32)
    begin : g_cnt_w_bad
        $error("CNT_W must be 1 to 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Three-way compare; high bit off means don't-care
    function automatic logic tri_ok(input logic [1:0] sel,
                                    input logic equal);
        tri_ok = !sel[1] || (sel[0] == equal); // R16 R17
    endfunction

    // Protocol address filter in host or network mode
    function automatic logic ip_ok(input logic [1:0] mode,
                                   input logic [31:0] frame_ip,
                                   input logic [31:0] addr,
                                   input logic [31:0] mask);
        case (ipmode_t'(mode))
            IP_HOST: ip_ok = (frame_ip == addr); // R7 R9
            IP_NET: ip_ok = ((frame_ip ^ addr) & mask) == 32'h0; // R8 R10
            default: ip_ok = 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0] cfg0; // VLAN and ARP selections
    logic [31:0] cfg1; // Header checks and frame type
    logic [31:0] sip_addr; // Sender IP address
    logic [31:0] sip_mask; // Sender IP mask
    logic [31:0] tip_addr; // Target IP address
    logic [31:0] tip_mask; // Target IP mask
    logic [CNT_W-1:0] hit_count; // Hits since last clear
    logic [1:0] status; // Last hit and decision seen

    // Bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes commit at the edge where the master samples ack high
    wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire [7:0] reg_off = {wb_adr_i[7:2], 2'b00};
    wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire wr_cfg0 = bus_wr && reg_off == `REG_CFG0;
    wire wr_cfg1 = bus_wr && reg_off == `REG_CFG1;
    wire wr_sip_a = bus_wr && reg_off == `REG_SIP_ADDR;
    wire wr_sip_m = bus_wr && reg_off == `REG_SIP_MASK;
    wire wr_tip_a = bus_wr && reg_off == `REG_TIP_ADDR;
    wire wr_tip_m = bus_wr && reg_off == `REG_TIP_MASK;
    // Any write to the counter clears it
    wire clr_count = bus_wr && reg_off == `REG_HIT_CNT;

    // Byte-lane merge of write data
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [31:0] bm);
        merge = (old & ~bm) | (wdat & bm);
    endfunction

    // Unused bits are kept at zero so they read back as zero
    wire [31:0] cfg0_keep = {{(31-`CFG0_USED_MSB){1'b0}},
                             {(`CFG0_USED_MSB+1){1'b1}}};
    wire [31:0] cfg1_keep = {{(31-`CFG1_USED_MSB){1'b0}},
                             {(`CFG1_USED_MSB+1){1'b1}}};

    wire [31:0] next_cfg0 = merge(cfg0, wb_dat_i, byte_mask) & cfg0_keep;
    wire [31:0] next_cfg1 = merge(cfg1, wb_dat_i, byte_mask) & cfg1_keep;

    // Read multiplexer; unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        case (reg_off)
            `REG_CFG0: rd_mux = cfg0;
            `REG_CFG1: rd_mux = cfg1;
            `REG_SIP_ADDR: rd_mux = sip_addr;
            `REG_SIP_MASK: rd_mux = sip_mask;
            `REG_TIP_ADDR: rd_mux = tip_addr;
            `REG_TIP_MASK: rd_mux = tip_mask;
            `REG_HIT_CNT: rd_mux = 32'(hit_count);
            `REG_STATUS: rd_mux = {30'h0, status};
            default: rd_mux = 32'h0;
        endcase
    end

    // Ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : 32'h0;
        end
    end

    // Configuration storage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg0 <= `CFG0_RST;
            cfg1 <= `CFG1_RST;
            sip_addr <= `ADDR_RST;
            sip_mask <= `ADDR_RST;
            tip_addr <= `ADDR_RST;
            tip_mask <= `ADDR_RST;
        end
        else
        begin
            if (wr_cfg0) cfg0 <= next_cfg0;
            if (wr_cfg1) cfg1 <= next_cfg1;
            if (wr_sip_a) sip_addr <= merge(sip_addr, wb_dat_i, byte_mask);
            if (wr_sip_m) sip_mask <= merge(sip_mask, wb_dat_i, byte_mask);
            if (wr_tip_a) tip_addr <= merge(tip_addr, wb_dat_i, byte_mask);
            if (wr_tip_m) tip_mask <= merge(tip_mask, wb_dat_i, byte_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Match logic, purely combinational on parser fields

    // Configuration fields
    wire [11:0] cfg_vid = cfg0[`VID_MSB:`VID_LSB];
    wire vid_spec = cfg0[`VID_SPEC_BIT];
    wire [2:0] cfg_prio = cfg0[`PRIO_MSB:`PRIO_LSB];
    wire prio_spec = cfg0[`PRIO_SPEC_BIT];
    wire [1:0] opcls = cfg0[`OPCLS_LSB +: 2];
    wire [1:0] reqrep = cfg0[`REQREP_LSB +: 2];
    wire [1:0] sip_mode = cfg0[`SIPMODE_LSB +: 2];
    wire [1:0] tip_mode = cfg0[`TIPMODE_LSB +: 2];
    wire [1:0] sha_chk = cfg0[`SHACHK_LSB +: 2];
    wire [1:0] tha_chk = cfg0[`THACHK_LSB +: 2];
    wire [1:0] len_chk = cfg1[`LENCHK_LSB +: 2];
    wire [1:0] hrd_chk = cfg1[`HRDCHK_LSB +: 2];
    wire [1:0] pro_chk = cfg1[`PROCHK_LSB +: 2];
    wire [2:0] ftype = cfg1[`FTYPE_LSB +: 3];

    // Frame type selection; illegal codes never match
    logic type_ok;
    always_comb
    begin
        case (ftype_sel_t'(ftype))
            FT_ANY: type_ok = 1'b1;
            FT_ETYPE: type_ok = (frm_kind_i == FK_ETYPE);
            FT_ARP: type_ok = (frm_kind_i == FK_ARP);
            FT_IPV4: type_ok = (frm_kind_i == FK_IPV4);
            FT_IPV6: type_ok = (frm_kind_i == FK_IPV6);
            default: type_ok = 1'b0;
        endcase
    end

    // VLAN ID 0 is outside the legal range, so it never matches
    wire vid_ok = !vid_spec || // R1
        (cfg_vid != `VID_NONE && frm_vid_i == cfg_vid); // R2
    wire prio_ok = !prio_spec || frm_prio_i == cfg_prio; // R3
    wire base_ok = type_ok && vid_ok && prio_ok;

    // Opcode decoding
    wire is_arp_op = arp_op_i == `OP_ARP_REQ || arp_op_i == `OP_ARP_REP;
    wire is_rarp_op = arp_op_i == `OP_RARP_REQ ||
        arp_op_i == `OP_RARP_REP;
    wire is_req = arp_op_i == `OP_ARP_REQ || arp_op_i == `OP_RARP_REQ;
    wire is_rep = arp_op_i == `OP_ARP_REP || arp_op_i == `OP_RARP_REP;

    logic opcls_ok;
    always_comb
    begin
        unique case (opcls_t'(opcls)) // R5
            OC_ANY: opcls_ok = 1'b1;
            OC_ARP: opcls_ok = is_arp_op;
            OC_RARP: opcls_ok = is_rarp_op;
            OC_OTHER: opcls_ok = !is_arp_op && !is_rarp_op;
        endcase
    end

    logic reqrep_ok;
    always_comb
    begin
        unique case (reqrep_t'(reqrep)) // R6
            RR_REQ: reqrep_ok = is_req;
            RR_REP: reqrep_ok = is_rep;
            RR_ANY, RR_ANY_ALT: reqrep_ok = 1'b1;
        endcase
    end

    wire sip_ok = ip_ok(sip_mode, arp_sender_ip_i, sip_addr, sip_mask);
    wire tip_ok = ip_ok(tip_mode, arp_target_ip_i, tip_addr, tip_mask);
    wire sha_ok = tri_ok(sha_chk,
        arp_sender_hw_i == frame_source_mac_i); // R11
    // The target hardware check only qualifies RARP frames
    wire tha_ok = !tha_chk[1] || (is_rarp_op && tri_ok(tha_chk,
        arp_target_hw_i == frame_source_mac_i)); // R12
    wire len_ok = tri_ok(len_chk, arp_hln_i == `HLN_ETH &&
        arp_pln_i == `PLN_IPV4); // R13
    wire hrd_ok = tri_ok(hrd_chk, arp_hrd_i == `HRD_ETH); // R14
    wire pro_ok = tri_ok(pro_chk, arp_pro_i == `PRO_IPV4); // R15

    wire arp_all = opcls_ok && reqrep_ok && sip_ok && tip_ok &&
        sha_ok && tha_ok && len_ok && hrd_ok && pro_ok;
    // ARP checks only count when the entry selects ARP frames
    wire arp_sel = ftype == FT_ARP;
    wire arp_ok = !arp_sel || arp_all; // R4
    wire all_ok = base_ok && arp_ok; // R18
    wire frame_hit = frm_valid_i && all_ok;

    ////////////////////////////////////////////////////////////////////////
    // Decision outputs, counter and status

    // Decision registered one cycle after the parser strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            decided_o <= 1'b0;
            hit_o <= 1'b0;
            status <= 2'b00;
        end
        else
        begin
            decided_o <= frm_valid_i;
            hit_o <= frame_hit;
            if (frm_valid_i)
                status <= {1'b1, all_ok};
        end
    end

    // A hit in the clearing cycle is kept as count one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            hit_count <= '0;
        else if (clr_count)
            hit_count <= frame_hit ? CNT_W'(1) : '0; // R19
        else if (frame_hit)
            hit_count <= hit_count + CNT_W'(1); // R19
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_hit_and: assert property ( // R18
        frm_valid_i |=> hit_o == $past(all_ok))
        else $error("hit differs from combined criteria");
    chk_count_step: assert property ( // R19
        hit_o && !$past(clr_count) |->
        hit_count == $past(hit_count) + CNT_W'(1))
        else $error("hit counter did not step");
    chk_vid_equal: assert property ( // R2
        frm_valid_i && vid_spec && frm_vid_i != cfg_vid |=> !hit_o)
        else $error("hit with wrong VLAN ID");
    chk_prio_equal: assert property ( // R3
        frm_valid_i && prio_spec && frm_prio_i != cfg_prio |=> !hit_o)
        else $error("hit with wrong tag priority");
    chk_arp_gate: assert property ( // R4
        frm_valid_i && !arp_sel |=> hit_o == $past(base_ok))
        else $error("ARP checks applied to non-ARP entry");
    chk_opclass_arp: assert property ( // R5
        frm_valid_i && arp_sel && opcls == OC_ARP && !is_arp_op
        |=> !hit_o)
        else $error("hit with non-ARP opcode");
    chk_sip_host: assert property ( // R7
        frm_valid_i && arp_sel && sip_mode == IP_HOST &&
        arp_sender_ip_i != sip_addr |=> !hit_o)
        else $error("hit with wrong sender IP");
    chk_tip_net: assert property ( // R10
        frm_valid_i && arp_sel && tip_mode == IP_NET &&
        ((arp_target_ip_i ^ tip_addr) & tip_mask) != 32'h0 |=> !hit_o)
        else $error("hit outside target network");
    chk_len_eq: assert property ( // R13
        frm_valid_i && arp_sel && len_chk == TW_EQ &&
        arp_hln_i != `HLN_ETH |=> !hit_o)
        else $error("hit with wrong address length");
    chk_bus_ack: assert property (
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");

    cov_arp_hit: cover property (frm_valid_i && arp_sel ##1 hit_o);
    cov_vlan_hit: cover property (frm_valid_i && vid_spec ##1 hit_o);
    cov_clear_hit: cover property (clr_count && frame_hit);
    cov_miss: cover property (decided_o && !hit_o);

endmodule // acl_vlan_arp_matcher

// *** verif/acl_vlan_arp_matcher_tb_top.sv ***
`timescale 1ns/1ps
`include "acl_match_consts.svh"
module acl_vlan_arp_matcher_tb_top;
    import acl_match_pkg::*;
    logic clk_i = 1'b0; // 200 MHz
    logic rst_i = 1'b1; // Held 4 cycles
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [7:0] wb_adr = 8'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, q, r;
    logic f_valid, decided, hit, last, fai;
    frame_kind_t f_kind, fk; // Driven kind, planned kind
    logic [11:0] f_vid, fv;
    logic [2:0] f_prio, fp;
    logic [47:0] f_mac, f_sha, f_tha, fs, fsh, fth;
    logic [15:0] f_op, f_hrd, f_pro, fo, fh, fr;
    logic [7:0] f_hln, f_pln, fl, fn;
    logic [31:0] f_sip, f_tip, fsi, fti;
    logic [31:0] cfg0, cfg1, sa, sm, ta, tm, exp_cnt = 32'h0;
    logic [15:0] seed = 16'hb4aa; // 46250
    logic [11:0] vt [4] = '{12'h0, 12'hfff, 12'hfff, 12'h1};
    logic [11:0] ft [4] = '{12'h0, 12'hfff, 12'hffe, 12'h1};
    int error_cnt = 0, n_compared = 0, cyc_n = 0;

    acl_vlan_arp_matcher dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .frm_valid_i(f_valid),
        .frm_kind_i(f_kind), .frm_vid_i(f_vid), .frm_prio_i(f_prio),
        .frame_source_mac_i(f_mac), .arp_op_i(f_op), .arp_hrd_i(f_hrd),
        .arp_pro_i(f_pro), .arp_hln_i(f_hln), .arp_pln_i(f_pln),
        .arp_sender_hw_i(f_sha), .arp_sender_ip_i(f_sip),
        .arp_target_hw_i(f_tha), .arp_target_ip_i(f_tip),
        .decided_o(decided), .hit_o(hit));
    arp_frame_source src (.clk_i(clk_i), .frm_valid_o(f_valid),
        .frm_kind_o(f_kind), .vid_o(f_vid), .prio_o(f_prio),
        .frame_source_mac_o(f_mac), .op_o(f_op), .hrd_o(f_hrd),
        .pro_o(f_pro), .hln_o(f_hln), .pln_o(f_pln), .sha_o(f_sha),
        .sip_o(f_sip), .tha_o(f_tha), .tip_o(f_tip));

    ////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk1(input string nm, input logic e, input logic s);
        n_compared++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task chk32(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // Stimulus source: 16-bit LFSR, one bit per step
    function logic [31:0] rnd();
        for (int i = 0; i < 32; i++)
        begin
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
            rnd[i] = seed[0];
        end
    endfunction
    function automatic logic tw(input logic [1:0] c, input logic eq);
        return c[1] ? (c[0] == eq) : 1'b1;
    endfunction
    function automatic logic ipm(input logic [1:0] m,
        input logic [31:0] f, input logic [31:0] a, input logic [31:0] k);
        return m == 2'h1 ? f == a : m == 2'h2 ? (f & k) == (a & k) : 1'b1;
    endfunction
    // Expected decision from the planned frame and configuration
    function logic exp_hit();
        logic t, ar, rr, rq, rp;
        logic [2:0] ty;
        ty = cfg1[8:6];
        ar = fo == 16'h1 || fo == 16'h2;
        rr = fo == 16'h3 || fo == 16'h4;
        rq = fo == 16'h1 || fo == 16'h3;
        rp = fo == 16'h2 || fo == 16'h4;
        t = ty == 3'h0 || (ty == 3'h1 && fk == FK_ETYPE)
            || (ty == 3'h2 && fk == FK_ARP) || (ty == 3'h3 && fk == FK_IPV4)
            || (ty == 3'h4 && fk == FK_IPV6);
        t &= !cfg0[12] || (cfg0[11:0] != 12'h0 && fv == cfg0[11:0]);
        t &= !cfg0[16] || fp == cfg0[15:13];
        if (ty == 3'h2)
        begin
            t &= cfg0[18:17] == 2'h0 || (cfg0[18:17] == 2'h1 && ar)
                || (cfg0[18:17] == 2'h2 && rr)
                || (cfg0[18:17] == 2'h3 && !ar && !rr);
            t &= cfg0[20:19] == 2'h0 || cfg0[20:19] == 2'h3
                || (cfg0[20:19] == 2'h1 && rq)
                || (cfg0[20:19] == 2'h2 && rp);
            t &= ipm(cfg0[22:21], fsi, sa, sm);
            t &= ipm(cfg0[24:23], fti, ta, tm);
            t &= tw(cfg0[26:25], fsh == fs);
            t &= !cfg0[28] || (rr && cfg0[27] == (fth == fs));
            t &= tw(cfg1[1:0], fl == `HLN_ETH && fn == `PLN_IPV4);
            t &= tw(cfg1[3:2], fh == `HRD_ETH);
            t &= tw(cfg1[5:4], fr == `PRO_IPV4);
        end
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Wishbone classic master: hold until ack, release after it
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        wb_sel <= s;
        @(posedge clk_i);
        while (wb_ack !== 1'b1)
            @(posedge clk_i);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task write_cfg();
        wb(`REG_CFG0, 1'b1, cfg0, 4'hf);
        wb(`REG_CFG1, 1'b1, cfg1, 4'hf);
        wb(`REG_SIP_ADDR, 1'b1, sa, 4'hf);
        wb(`REG_SIP_MASK, 1'b1, sm, 4'hf);
        wb(`REG_TIP_ADDR, 1'b1, ta, 4'hf);
        wb(`REG_TIP_MASK, 1'b1, tm, 4'hf);
    endtask
    // Sparse settings, so that most criteria stay don't-care
    task rand_cfg();
        r = rnd();
        cfg0 = rnd() & rnd() & 32'h1fff_f003;
        cfg0[1:0] = r[1:0];
        cfg1 = rnd() & rnd() & 32'h3f;
        cfg1[8:6] = r[2] ? 3'h2 : r[5:3];
        sa = {30'h3029_0040, r[7:6]};
        sm = r[8] ? 32'hffff_ffff : 32'hffff_fffc;
        ta = {30'h3029_0040, r[10:9]};
        tm = r[11] ? 32'hffff_ffff : 32'hffff_fffd;
        write_cfg();
    endtask
    task rand_frame();
        r = rnd();
        fk = r[2] ? FK_ARP : frame_kind_t'(r[1:0]);
        fv = {10'h0, r[4:3]};
        fp = r[7:5];
        fs = {46'h0, r[9:8]};
        fo = {13'h0, r[12:10]};
        fh = r[13] ? 16'h0001 : 16'h0002;
        fr = r[14] ? 16'h0800 : 16'h0806;
        fl = r[15] ? 8'h06 : 8'h08;
        fn = r[16] ? 8'h04 : 8'h06;
        fsh = r[17] ? fs : fs ^ 48'h1;
        fth = r[18] ? fs : ~fs;
        fsi = {30'h3029_0040, r[20:19]};
        fti = {30'h3029_0040, r[22:21]};
    endtask
    task run_frame();
        fai = exp_hit();
        src.send(fk, fv, fp, fs, fo, fh, fr, fl, fn, fsh, fsi, fth, fti);
        @(posedge clk_i);
        chk1("decided", 1'b1, decided);
        chk1("hit", fai, hit);
        exp_cnt += {31'h0, fai};
        last = fai;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset contents, then the unmapped hole at 0x20
        for (int a = 0; a <= 32; a += 4)
        begin
            wb(a[7:0], 1'b0, 32'h0, 4'h0);
            chk32("reset_reg", 32'h0, q);
        end
        wb(`REG_CFG0, 1'b1, 32'hffff_ffff, 4'hf);
        wb(`REG_CFG0, 1'b1, 32'h0, 4'h2);
        wb(8'h20, 1'b1, 32'hffff_ffff, 4'hf);
        wb(`REG_CFG0, 1'b0, 32'h0, 4'h0);
        chk32("cfg0_lanes", 32'h1fff_00ff, q);
        wb(8'h20, 1'b0, 32'h0, 4'h0);
        chk32("unmapped", 32'h0, q);
        // VLAN identifier edges: 0 never, 4095 exact
        rand_frame();
        {cfg1, sa, sm, ta, tm} = '0;
        for (int i = 0; i < 4; i++)
        begin
            cfg0 = {19'h0, 1'b1, vt[i]};
            fv = ft[i];
            write_cfg();
            run_frame();
        end
        repeat (300)
        begin
            rand_cfg();
            repeat (4)
            begin
                rand_frame();
                run_frame();
            end
            wb(`REG_HIT_CNT, 1'b0, 32'h0, 4'h0);
            chk32("hit_cnt", exp_cnt, q);
            wb(`REG_STATUS, 1'b0, 32'h0, 4'h0);
            chk32("status", {30'h0, 1'b1, last}, q);
            if (r[0])
            begin
                wb(`REG_HIT_CNT, 1'b1, 32'h0, 4'hf);
                exp_cnt = 32'h0;
            end
        end
        // Mid-run reset after a known hit clears counter and status
        {cfg0, cfg1} = '0;
        write_cfg();
        run_frame();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(`REG_HIT_CNT, 1'b0, 32'h0, 4'h0);
        chk32("rst_cnt", 32'h0, q);
        wb(`REG_STATUS, 1'b0, 32'h0, 4'h0);
        chk32("rst_status", 32'h0, q);
        wb(`REG_CFG1, 1'b0, 32'h0, 4'h0);
        chk32("rst_cfg1", 32'h0, q);
        print_verdict();
    end
endmodule // acl_vlan_arp_matcher_tb_top

// *** verif/arp_frame_source.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Ingress parser stand-in: one header strobe per frame
module arp_frame_source
(
    input wire logic clk_i, // Bench clock
    output logic frm_valid_o = 1'b0, // Header fields valid
    output acl_match_pkg::frame_kind_t frm_kind_o = acl_match_pkg::FK_ETYPE,
    output logic [11:0] vid_o = 12'h0, // VLAN identifier
    output logic [2:0] prio_o = 3'h0, // Tag priority
    output logic [47:0] frame_source_mac_o = 48'h0, // Source MAC
    output logic [15:0] op_o = 16'h0, // Opcode
    output logic [15:0] hrd_o = 16'h0, // Hardware space
    output logic [15:0] pro_o = 16'h0, // Protocol space
    output logic [7:0] hln_o = 8'h0, // Hardware length
    output logic [7:0] pln_o = 8'h0, // Protocol length
    output logic [47:0] sha_o = 48'h0, // Sender hardware
    output logic [31:0] sip_o = 32'h0, // Sender IP
    output logic [47:0] tha_o = 48'h0, // Target hardware
    output logic [31:0] tip_o = 32'h0 // Target IP
);
    import acl_match_pkg::*;

    // One frame: fields valid for exactly one cycle
    task send(input frame_kind_t k, input logic [11:0] v,
        input logic [2:0] p, input logic [47:0] s, input logic [15:0] o,
        input logic [15:0] h, input logic [15:0] r, input logic [7:0] l,
        input logic [7:0] n, input logic [47:0] sh, input logic [31:0] si,
        input logic [47:0] th, input logic [31:0] ti);
        @(posedge clk_i);
        frm_valid_o <= 1'b1;
        frm_kind_o <= k;
        {vid_o, prio_o, frame_source_mac_o, op_o, hrd_o, pro_o, hln_o,
            pln_o, sha_o, sip_o, tha_o, tip_o} <= {v, p, s, o, h, r, l, n,
            sh, si, th, ti};
        @(posedge clk_i);
        frm_valid_o <= 1'b0;
        // Idle fields show the inverse, so a stale copy cannot pass
        frm_kind_o <= frame_kind_t'(~k);
        {vid_o, prio_o, frame_source_mac_o, op_o, hrd_o, pro_o, hln_o,
            pln_o, sha_o, sip_o, tha_o, tip_o} <= ~{v, p, s, o, h, r, l, n,
            sh, si, th, ti};
    endtask
endmodule // arp_frame_source
